//--- src/rsa_pkg.sv
// constants and types for the range-select and alarm-status register bank
// assumes a 32-bit classic wishbone slave with byte addresses, one 100 MHz clock
package rsa_pkg;

  // bus geometry
  localparam int          ADR_W        = 8;      // byte address width
  localparam int          DAT_W        = 32;     // data width
  localparam int          SEL_W        = 4;      // byte enables

  // register byte offsets
  localparam logic [7:0]  RANGE_OFS    = 8'h14;  // input_range_select
  localparam logic [7:0]  ALARM_OFS    = 8'h20;  // alarm_status_flags
  localparam logic [7:0]  OUTCTL_OFS   = 8'h40;  // output frame control
  localparam logic [7:0]  IRQ_STAT_OFS = 8'h44;  // sticky event status
  localparam logic [7:0]  IRQ_MASK_OFS = 8'h48;  // event mask

  // input_range_select fields
  localparam int          RANGE_LSB    = 0;      // range code lsb
  localparam int          RANGE_W      = 4;      // range code width
  localparam int          REF_OFF_BIT  = 6;      // internal_reference_off

  // alarm_status_flags fields
  localparam int          ACT_SUP_LO   = 15;     // live supply low
  localparam int          ACT_SUP_HI   = 14;     // live supply high
  localparam int          ACT_IN_LO    = 11;     // live input low
  localparam int          ACT_IN_HI    = 10;     // live input high
  localparam int          TRP_LSB      = 4;      // latched flags, bits 7..4
  localparam int          ANY_BIT      = 0;      // any_latched_alarm

  // output control and interrupt fields
  localparam int          APPEND_LSB   = 0;      // append_live_input_alarms
  localparam int          EVT_LSB      = 0;      // event bits 3..0

  // reset values
  localparam logic [3:0]  RANGE_RST    = 4'h0;
  localparam logic        REF_OFF_RST  = 1'b0;
  localparam logic [1:0]  APPEND_RST   = 2'h0;
  localparam logic [3:0]  FLAGS_RST    = 4'h0;

  // alarm group, also the layout of latched and event bits (msb first)
  typedef struct packed {
    logic sup_low;
    logic sup_high;
    logic in_low;
    logic in_high;
  } rsa_alarm_t;

  // append_live_input_alarms codes
  typedef enum logic [1:0] {
    RSA_APPEND_NONE = 2'b00,
    RSA_APPEND_HIGH = 2'b01,
    RSA_APPEND_LOW  = 2'b10,
    RSA_APPEND_BOTH = 2'b11
  } rsa_append_t;

  // bus answer states
  typedef enum logic [1:0] {
    RSA_BUS_IDLE = 2'b01,
    RSA_BUS_ACK  = 2'b10
  } rsa_bus_t;

endpackage

//--- src/rsa_regs.sv
// range-select and alarm-status register bank with wishbone slave and irq
// assumes alarm comparators outside are asynchronous; reset is synchronous
`timescale 1ns/1ps

// What this block does
// - range-select reserved bits read zero, ignore writes
// - bit 6 disables internal reference, resets zero
// - bits 3..0 pick one of nine ranges
// - application reset keeps programmed range code
// - range-select bytes sit at 14h to 17h
// - live alarm flags at bits 15,14,11,10
// - latched alarm flags at bits 7 to 4
// - bit 0 is OR of latched flags
// - alarm-status reserved bits read zero
// - alarm-status bytes sit at 20h to 23h
// - two-bit control appends live input flags
module rsa_regs
  import rsa_pkg::*;
(
  input  wire logic             i_core_clk,    // 100 MHz core clock
  input  wire logic             i_rst,         // power-on reset, sync high
  input  wire logic             i_app_rst,     // application reset, sync high
  input  wire logic             i_wb_cyc,      // wishbone cycle
  input  wire logic             i_wb_stb,      // wishbone strobe
  input  wire logic             i_wb_we,       // wishbone write
  input  wire logic [ADR_W-1:0] i_wb_adr,      // byte address
  input  wire logic [SEL_W-1:0] i_wb_sel,      // byte enables
  input  wire logic [DAT_W-1:0] i_wb_dat,      // write data
  output logic                  o_wb_ack,      // answer, one cycle
  output logic      [DAT_W-1:0] o_wb_dat,      // read data
  input  wire rsa_alarm_t       i_alarm_cond,  // raw comparator levels
  output logic      [3:0]       o_range_sel,   // selected range code
  output logic                  o_ref_off,     // internal_reference_off
  output logic      [1:0]       o_live_append, // {low, high} live flags for frame
  output logic                  o_irq          // level interrupt
);

  // bus state
  rsa_bus_t         bus_q, bus_d;              // answer phase
  logic [DAT_W-1:0] rdat_q, rdat_d;            // registered read data

  // configuration state
  logic [3:0]       range_q, range_d;          // survives application reset
  logic             ref_off_q, ref_off_d;      // reference disable
  logic [1:0]       append_q, append_d;        // frame append control
  logic [3:0]       mask_q, mask_d;            // interrupt mask

  // alarm state
  rsa_alarm_t       sync1_q, sync1_d;          // first sync stage, read by sync2 only
  rsa_alarm_t       live_q, live_d;            // second stage, the live flags
  rsa_alarm_t       prev_q, prev_d;            // live one cycle ago, for edges
  rsa_alarm_t       trip_q, trip_d;            // latched flags
  rsa_alarm_t       evt_q, evt_d;              // sticky interrupt status
  logic [1:0]       lapp_q, lapp_d;            // frame append output
  logic             irq_q, irq_d;              // interrupt output

  // decode helpers
  logic             req;                       // new request, not yet answered
  logic             wr, rd;                    // request with direction
  logic             hit_range, hit_alarm;      // address matches
  logic             hit_outctl, hit_stat, hit_mask;
  logic             soft_rst;                  // app reset clears non-range config and alarm state
  rsa_alarm_t       rise;                      // alarm onsets this cycle
  rsa_alarm_t       w1c;                       // status bits written one

  // request decode; answering takes one wait state
  always_comb begin
    req        = i_wb_cyc && i_wb_stb && (bus_q == RSA_BUS_IDLE);
    wr         = req && i_wb_we;
    rd         = req && !i_wb_we;
    hit_range  = (i_wb_adr[ADR_W-1:2] == RANGE_OFS[ADR_W-1:2]);
    hit_alarm  = (i_wb_adr[ADR_W-1:2] == ALARM_OFS[ADR_W-1:2]);
    hit_outctl = (i_wb_adr[ADR_W-1:2] == OUTCTL_OFS[ADR_W-1:2]);
    hit_stat   = (i_wb_adr[ADR_W-1:2] == IRQ_STAT_OFS[ADR_W-1:2]);
    hit_mask   = (i_wb_adr[ADR_W-1:2] == IRQ_MASK_OFS[ADR_W-1:2]);
    soft_rst   = i_app_rst;
  end

  // bus answer: ack one cycle after the request, then back to idle
  always_comb begin
    bus_d  = bus_q;
    rdat_d = rdat_q;
    unique case (bus_q)
      RSA_BUS_IDLE: begin
        if (req) begin
          bus_d  = RSA_BUS_ACK;
          rdat_d = '0;                           // unmapped reads give zero
          if (rd && hit_range) begin
            rdat_d[RANGE_LSB +: RANGE_W] = range_q;
            rdat_d[REF_OFF_BIT]          = ref_off_q;
          end                                             // rest stays zero
          if (rd && hit_alarm) begin
            rdat_d[ACT_SUP_LO]           = live_q.sup_low;
            rdat_d[ACT_SUP_HI]           = live_q.sup_high;
            rdat_d[ACT_IN_LO]            = live_q.in_low;
            rdat_d[ACT_IN_HI]            = live_q.in_high;
            rdat_d[TRP_LSB +: 4]         = trip_q;
            rdat_d[ANY_BIT]              = |trip_q;
          end                                               // rest stays zero
          if (rd && hit_outctl) begin
            rdat_d[APPEND_LSB +: 2] = append_q;
          end
          if (rd && hit_stat) begin
            rdat_d[EVT_LSB +: 4] = evt_q;
          end
          if (rd && hit_mask) begin
            rdat_d[EVT_LSB +: 4] = mask_q;
          end
        end
      end
      RSA_BUS_ACK: begin
        bus_d = RSA_BUS_IDLE;                    // master releases after ack
      end
    endcase
    if (i_rst) begin
      bus_d  = RSA_BUS_IDLE;
      rdat_d = '0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    bus_q  <= bus_d;
    rdat_q <= rdat_d;
  end

  // configuration writes; only byte lane 0 holds writable bits
  always_comb begin
    range_d   = range_q;
    ref_off_d = ref_off_q;
    append_d  = append_q;
    mask_d    = mask_q;
    if (wr && i_wb_sel[0]) begin
      if (hit_range) begin
        range_d   = i_wb_dat[RANGE_LSB +: RANGE_W];
        ref_off_d = i_wb_dat[REF_OFF_BIT];
      end                                                  // others dropped
      if (hit_outctl) begin
        append_d = i_wb_dat[APPEND_LSB +: 2];
      end
      if (hit_mask) begin
        mask_d = i_wb_dat[EVT_LSB +: 4];
      end
    end
    // application reset leaves the range code alone
    if (soft_rst) begin
      ref_off_d = REF_OFF_RST;
      append_d  = APPEND_RST;
      mask_d    = FLAGS_RST;
    end
    if (i_rst) begin
      range_d   = RANGE_RST;
      ref_off_d = REF_OFF_RST;
      append_d  = APPEND_RST;
      mask_d    = FLAGS_RST;
    end
  end

  always_ff @(posedge i_core_clk) begin
    range_q   <= range_d;
    ref_off_q <= ref_off_d;
    append_q  <= append_d;
    mask_q    <= mask_d;
  end

  // alarm capture, latching and interrupt status
  always_comb begin
    sync1_d = i_alarm_cond;
    live_d  = sync1_q;                          // second stage only reads first
    prev_d  = live_q;
    rise    = live_q & ~prev_q;
    w1c     = (wr && hit_stat && i_wb_sel[0]) ? i_wb_dat[EVT_LSB +: 4] : FLAGS_RST;
    // read clears, but a live condition sets in the same cycle and wins
    trip_d  = (rd && hit_alarm) ? FLAGS_RST : trip_q;
    trip_d  = trip_d | live_q;
    evt_d   = (evt_q & ~w1c) | rise;            // set beats clear
    lapp_d  = append_q & {live_q.in_low, live_q.in_high};
    if (soft_rst || i_rst) begin
      sync1_d = FLAGS_RST;
      live_d  = FLAGS_RST;
      prev_d  = FLAGS_RST;
      trip_d  = FLAGS_RST;
      evt_d   = FLAGS_RST;
      lapp_d  = APPEND_RST;
    end
    // mask from next values so irq tracks status without extra lag
    irq_d = |(evt_d & mask_d);
  end

  always_ff @(posedge i_core_clk) begin
    sync1_q <= sync1_d;
    live_q  <= live_d;
    prev_q  <= prev_d;
    trip_q  <= trip_d;
    evt_q   <= evt_d;
    lapp_q  <= lapp_d;
    irq_q   <= irq_d;
  end

  // outputs straight from flops, except ack, which is decoded from bus_q
  assign o_wb_ack      = (bus_q == RSA_BUS_ACK);
  assign o_wb_dat      = rdat_q;
  assign o_range_sel   = range_q;
  assign o_ref_off     = ref_off_q;
  assign o_live_append = lapp_q;
  assign o_irq         = irq_q;

  // checks, all on the core clock and quiet while power-on reset is high
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // read in flight, so data checks know which register answers
  logic rd_range_q, rd_range_d;                 // range-select read pending
  logic rd_alarm_q, rd_alarm_d;                 // alarm-status read pending

  // next values of the read trackers
  always_comb begin
    rd_range_d = rd && hit_range;
    rd_alarm_d = rd && hit_alarm;
  end

  // trackers only register
  always_ff @(posedge i_core_clk) begin
    rd_range_q <= rd_range_d;
    rd_alarm_q <= rd_alarm_d;
  end

  // every taken request is answered on the next edge
  a_ack_after_req:
    assert property (req |=> o_wb_ack)
    else $error("request not answered in one cycle");

  // ack is a single-cycle pulse, so a held request is not taken twice
  a_ack_one_cycle:
    assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack stood longer than one cycle");

  // no answer without a taken request
  a_ack_needs_req:
    assert property (!req |=> !o_wb_ack)
    else $error("ack without a request");

  // reserved range-select bits answer zero
  a_range_rsvd_zero:
    assert property (o_wb_ack && rd_range_q |-> o_wb_dat[31:7] == '0 && o_wb_dat[5:4] == '0)
    else $error("range-select reserved bits not zero");

  // reference disable takes the written bit
  a_ref_off_write:
    assert property (wr && hit_range && i_wb_sel[0] && !i_app_rst |=>
                     o_ref_off == $past(i_wb_dat[REF_OFF_BIT]))
    else $error("reference disable not written");

  // application reset turns the internal reference back on
  a_ref_off_app:
    assert property (i_app_rst |=> !o_ref_off)
    else $error("application reset left reference off");

  // power-on reset leaves the reference enabled
  a_ref_off_por:
    assert property ($fell(i_rst) |-> !o_ref_off)
    else $error("reference off after power-on reset");

  // range code takes the written field
  a_range_write:
    assert property (wr && hit_range && i_wb_sel[0] |=>
                     o_range_sel == $past(i_wb_dat[3:0]))
    else $error("range code not written");

  // application reset must not touch the range code
  a_app_keeps_range:
    assert property (i_app_rst && !(wr && hit_range && i_wb_sel[0]) |=> $stable(o_range_sel))
    else $error("application reset changed range");

  // only power-on reset brings the range code home
  a_range_por:
    assert property ($fell(i_rst) |-> o_range_sel == RANGE_RST)
    else $error("range code not cleared by power-on reset");

  // writes to the upper byte lanes land nowhere
  a_upper_lanes_inert:
    assert property (wr && hit_range && !i_wb_sel[0] |=> $stable(o_range_sel))
    else $error("range changed without lane 0");

  // live flags read back as they stood when the read was taken
  a_live_flag_read:
    assert property (rd && hit_alarm |=>
                     o_wb_dat[15:14] == $past({live_q.sup_low, live_q.sup_high}) &&
                     o_wb_dat[11:10] == $past({live_q.in_low, live_q.in_high}))
    else $error("live alarm flags misread");

  // live flags are the comparator levels two edges late
  a_live_sync_path:
    assert property (!$past(i_rst) && !$past(i_app_rst) && !$past(i_rst, 2) &&
                     !$past(i_app_rst, 2) |-> live_q == $past(i_alarm_cond, 2))
    else $error("live flags do not follow synchronised levels");

  // an onset latches; only a read with the level gone, or application reset, may drop it again
  a_trip_latches:
    assert property ($rose(live_q.in_high) && !i_app_rst |=>
                     trip_q.in_high ##1 (trip_q.in_high || $past(rd && hit_alarm) ||
                                         $past(i_app_rst)))
    else $error("latched flag did not set");

  // summary bit is the OR of the latched nibble
  a_any_alarm_or:
    assert property (o_wb_ack && rd_alarm_q |-> o_wb_dat[0] == |o_wb_dat[7:4])
    else $error("summary flag not OR of latched");

  // reserved alarm-status bits answer zero
  a_alarm_rsvd_zero:
    assert property (o_wb_ack && rd_alarm_q |->
                     o_wb_dat[31:16] == '0 && o_wb_dat[13:12] == '0 &&
                     o_wb_dat[9:8] == '0 && o_wb_dat[3:1] == '0)
    else $error("alarm reserved bits not zero");

  // a status read with no live level clears every latched flag
  a_read_clears_trip:
    assert property (rd && hit_alarm && live_q == '0 && !i_app_rst |=> trip_q == '0)
    else $error("status read did not clear latched flags");

  // without a read the latched flag stays up
  a_trip_holds:
    assert property (trip_q.sup_low && !(rd && hit_alarm) && !i_app_rst |=> trip_q.sup_low)
    else $error("latched flag dropped without read");

  // frame append is the control code gating the live input flags
  a_append_select:
    assert property (!i_app_rst |=> o_live_append == ($past(append_q) &
                     $past({live_q.in_low, live_q.in_high})))
    else $error("appended flags wrong");

  // code none appends nothing, whatever the live levels do
  a_append_none:
    assert property (append_q == RSA_APPEND_NONE && !i_app_rst |=> o_live_append == 2'b00)
    else $error("flags appended with append off");

  // an onset raises its sticky status bit
  a_evt_onset:
    assert property ($rose(live_q.sup_low) && !i_app_rst |=> evt_q.sup_low)
    else $error("onset did not set status");

  // status bit holds until a one is written to it
  a_evt_sticky:
    assert property (evt_q.in_high && !(wr && hit_stat && i_wb_sel[0] && i_wb_dat[EVT_LSB]) &&
                     !i_app_rst |=> evt_q.in_high)
    else $error("status bit dropped without write one");

  // irq is a level, high while any unmasked status bit is set
  a_irq_level:
    assert property (o_irq == |(evt_q & mask_q))
    else $error("irq does not follow masked status");

endmodule

//--- bench/rsa_regs_tb.sv
// self-checking bench for the range-select and alarm-status register bank
// assumes the bench drives every port itself, a 100 MHz clock and sync resets
`timescale 1ns/1ps

module rsa_regs_tb;
  import rsa_pkg::*;

  logic             clk;          // core clock
  logic             rst;          // power-on reset
  logic             app_rst;      // application reset
  logic             cyc;          // wishbone cycle
  logic             stb;          // wishbone strobe
  logic             we;           // wishbone write
  logic [ADR_W-1:0] adr;          // byte address
  logic [DAT_W-1:0] wdat;         // write data
  logic [SEL_W-1:0] sel;          // byte enables
  logic             ack;          // slave answer
  logic [DAT_W-1:0] rdat;         // read data
  rsa_alarm_t       cond;         // alarm comparator levels
  logic [3:0]       range_sel;    // range code out
  logic             ref_off;      // reference disable out
  logic [1:0]       live_append;  // appended live flags
  logic             irq;          // level interrupt
  logic [DAT_W-1:0] rd;           // last read word
  int               errors;       // mismatch count
  int               checked;      // comparison count

  rsa_regs rsa_regs_inst (
    .i_core_clk    (clk),
    .i_rst         (rst),
    .i_app_rst     (app_rst),
    .i_wb_cyc      (cyc),
    .i_wb_stb      (stb),
    .i_wb_we       (we),
    .i_wb_adr      (adr),
    .i_wb_sel      (sel),
    .i_wb_dat      (wdat),
    .o_wb_ack      (ack),
    .o_wb_dat      (rdat),
    .i_alarm_cond  (cond),
    .o_range_sel   (range_sel),
    .o_ref_off     (ref_off),
    .o_live_append (live_append),
    .o_irq         (irq)
  );

  // free-running clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // four-state compare, x matches only x
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; request held until ack is sampled high, the watchdog bounds the wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // read and compare in one step
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(rd, exp);
  endtask

  // fixed wait, long enough for the three-edge alarm path
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask

  // reset values, reserved bits and all nine range codes
  task automatic t_range();
    logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'ha, 4'hb};
    rchk(8'h14, 32'h0);
    wb(1'b1, 8'h14, 32'hffff_ffff, 4'hf);
    rchk(8'h14, 32'h0000_004f);
    chk({31'h0, ref_off}, 32'h1);
    foreach (codes[i]) begin
      wb(1'b1, 8'h14, {28'h0, codes[i]}, 4'hf);
      rchk(8'h17, {28'h0, codes[i]});
      chk({28'h0, range_sel}, {28'h0, codes[i]});
    end
    // lanes 1..3 only: nothing writable there, range and reference stay
    wb(1'b1, 8'h14, 32'hffff_ff40, 4'he);
    rchk(8'h14, 32'h0000_000b);
  endtask

  // application reset keeps range, power-on reset clears it
  task automatic t_resets();
    wb(1'b1, 8'h15, 32'h0000_0049, 4'hf);
    @(posedge clk) app_rst <= 1'b1;
    @(posedge clk) app_rst <= 1'b0;
    rchk(8'h14, 32'h0000_0009);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    rchk(8'h16, 32'h0);
  endtask

  // live, latched and summary flags, clear on read
  task automatic t_alarm();
    @(posedge clk) cond <= 4'hf;
    settle();
    wb(1'b1, 8'h20, 32'h0, 4'hf);
    rchk(8'h20, 32'h0000_ccf1);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk) cond <= 4'h0;
    settle();
    rchk(8'h23, 32'h0000_00f1);
    rchk(8'h21, 32'h0);
    @(posedge clk) cond <= 4'h2;
    @(posedge clk) cond <= 4'h0;
    settle();
    rchk(8'h20, 32'h0000_0021);
    rchk(8'h80, 32'h0);
  endtask

  // append codes with both live input flags up
  task automatic t_append();
    @(posedge clk) cond <= 4'h3;
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, OUTCTL_OFS, c, 4'hf);
      settle();
      chk({30'h0, live_append}, c);
    end
    @(posedge clk) cond <= 4'h0;
    settle();
    chk({30'h0, live_append}, 32'h0);
  endtask

  // masked onset raises irq, write one clears it
  task automatic t_irq();
    wb(1'b1, IRQ_STAT_OFS, 32'hf, 4'hf);
    wb(1'b1, IRQ_MASK_OFS, 32'h1, 4'hf);
    @(posedge clk) cond <= 4'h1;
    settle();
    chk({31'h0, irq}, 32'h1);
    rchk(IRQ_STAT_OFS, 32'h1);
    wb(1'b1, IRQ_STAT_OFS, 32'h1, 4'hf);
    settle();
    chk({31'h0, irq}, 32'h0);
  endtask

  // verdict and end of run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // watchdog far beyond the expected few hundred cycles
  initial begin
    #200000;
    errors++;
    conclude();
  end

  // main sequence
  initial begin
    errors = 0;
    checked = 0;
    rst = 1'b1;
    app_rst = 1'b0;
    {cyc, stb, we} = 3'b000;
    adr = 8'h0;
    wdat = 32'h0;
    sel = 4'hf;
    cond = 4'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_range();
    t_resets();
    t_alarm();
    t_append();
    t_irq();
    conclude();
  end
endmodule
